// *** pkg/sui_defines.svh ***
// Overview of operation
// - Serial port works in clock polarity 0, phase 0 only; clock idles low.
// - Every word is full duplex: 16 bits in while 16 bits go out.
// - First two received bits select config write, config read, data write, data read.
// - Input bit is captured on each rising serial clock edge.
// - Bit 15 appears at select fall; bits 14 to 0 follow falling clock edges.
// - Select rising before the sixteenth bit abandons the word; nothing changes.
// - Effects of a complete word take place at the rising edge of select.
// - Each select fall restarts bit counting for a fresh 16-bit word.
// - Received characters are held in an eight-word receive FIFO.
// - Rates up to 230 kilobaud in standard and infrared framing are supported.
// - An indication flags received 9-bit network address characters.
// - Config write loads the 4-bit baud select; reset zero; config read returns it.
// - Read words report clear-to-send, 0 when the low-active pin is high; reset-proof.
// - Data write loads eight transmit bits; top bit dropped in 7-bit length.
// - Data read returns FIFO or buffer byte; resets zero; bit 7 zero in 7-bit.
// - FIFO enabled when the low-active enable bit is 0; resets 0; readable.
// - Infrared mode bit set to 1 selects pulse timing; resets to 0.
// - Serial output is high impedance whenever select is high.
// - Length bit 0 gives 8-bit characters, 1 gives 7-bit; resets to 0.
`ifndef SUI_DEFINES_SVH
`define SUI_DEFINES_SVH

// Word framing
`define SUI_WORD_BITS      5'h10
`define SUI_OP_HI          15
`define SUI_OP_LO          14
// Command codes in the first two bits
`define SUI_OP_WCFG        2'h3
`define SUI_OP_RCFG        2'h1
`define SUI_OP_WDAT        2'h2
`define SUI_OP_RDAT        2'h0
// Field positions, shared by written and returned words
`define SUI_POS_RXAVAIL    15
`define SUI_POS_TXROOM     14
`define SUI_POS_FIFODIS    13
`define SUI_POS_WORD7      11
`define SUI_POS_IRDA       10
`define SUI_POS_CTS        9
`define SUI_POS_ADDR       8
`define SUI_POS_DATA_MSB   7
`define SUI_POS_BAUD_MSB   3
// Reset values
`define SUI_BAUD_RST       4'h0
`define SUI_FIFODIS_RST    1'h0
`define SUI_WORD7_RST      1'h0
`define SUI_IRDA_RST       1'h0
`define SUI_RXBYTE_RST     8'h00
`define SUI_CS_SYNC_RST    3'h7
// Buffer sizes
`define SUI_FIFO_DEPTH     5'h08
`define SUI_TXBUF_DEPTH    2'h2

`endif

// *** pkg/sui_pkg.sv ***
`default_nettype none
`include "sui_defines.svh"

package sui_pkg;

  typedef enum logic [2:0] {
    SUI_IDLE  = 3'b001,
    SUI_SHIFT = 3'b010,
    SUI_HOLD  = 3'b100
  } sui_phase_t;

  typedef struct packed {
    logic [2:0]  sclk_q;
    logic [2:0]  cs_q;
    logic [1:0]  din_q;
    logic [1:0]  cts_q;
    sui_phase_t  phase;
    logic [4:0]  bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] out_word;
    logic        dout;
    logic        dout_oe_n;
    logic [3:0]  baud;
    logic        fifo_dis_n;
    logic        word7;
    logic        irda;
    logic [7:0]  rx_hold;
    logic        rx_hold_vld;
    logic        rx_rdy;
    logic        addr_seen;
    logic [7:0]  tx_d0;
    logic [7:0]  tx_d1;
    logic [1:0]  tx_cnt;
    logic        tx_vld;
    logic        fifo_pop;
  } sui_port_state_t;

  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [2:0]      wptr;
    logic [2:0]      rptr;
    logic [3:0]      level;
    logic [7:0]      rd_data;
  } sui_fifo_state_t;

endpackage
`default_nettype wire

// *** rtl/sui_rx_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sui_defines.svh"

module sui_rx_fifo (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  input  wire logic       rd_en_i,
  output logic [7:0]      rd_data_o,
  output logic            empty_o,
  output logic [3:0]      level_o
);

  sui_pkg::sui_fifo_state_t st;
  sui_pkg::sui_fifo_state_t next_st;
  logic                     do_wr;
  logic                     do_rd;

  // Full check allows a write when a read frees a slot in the same cycle
  assign do_rd = rd_en_i && (st.level != 4'h0);
  assign do_wr = wr_en_i && ((st.level != 4'(`SUI_FIFO_DEPTH)) || do_rd);

  // Pointer and level update; head byte is re-registered every cycle
  always_comb
  begin
    next_st = st;
    if (do_wr)
    begin
      next_st.mem[st.wptr] = wr_data_i;
      next_st.wptr         = st.wptr + 3'h1;
    end
    if (do_rd)
    begin
      next_st.rptr = st.rptr + 3'h1;
    end
    next_st.level   = st.level + {3'h0, do_wr} - {3'h0, do_rd};
    next_st.rd_data = st.mem[st.rptr];
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data_o = st.rd_data;
  assign empty_o   = (st.level == 4'h0);
  assign level_o   = st.level;

  a_fifo_depth: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    st.level <= 4'(`SUI_FIFO_DEPTH))
    else $error("receive FIFO level above eight");

  a_fifo_push: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    (wr_en_i && !rd_en_i && st.level < 4'h8) |=> st.level == $past(st.level) + 4'h1)
    else $error("receive FIFO write not counted");

endmodule // sui_rx_fifo
`default_nettype wire

// *** rtl/sui_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sui_defines.svh"

module sui_host_port (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  // Serial host pins
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       din_i,
  output logic            dout_o,
  output logic            dout_oe_n_o,
  // Handshake pin
  input  wire logic       cts_n_i,
  // Configuration toward the UART core
  output logic [3:0]      baud_divisor_select_o,
  output logic            fifo_disable_n_o,
  output logic            word_length_7_o,
  output logic            infrared_mode_o,
  // Transmit bytes toward the UART core
  output logic            tx_valid_o,
  output logic [7:0]      transmit_byte_o,
  input  wire logic       tx_ready_i,
  // Received characters from the UART core
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       rx_ninth_i,
  output logic            rx_ready_o,
  output logic            net_address_seen_o
);

  sui_pkg::sui_port_state_t st;
  sui_pkg::sui_port_state_t next_st;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;
  logic       commit;
  logic [1:0] op;
  logic       rx_take;
  logic       tx_pop;
  logic       fifo_wr;
  logic       fifo_empty;
  logic [7:0] fifo_rd_data;
  logic [3:0] fifo_level;

  // Edges seen only on the second and third sync stages
  assign sclk_rise = st.sclk_q[1] && !st.sclk_q[2];
  assign sclk_fall = !st.sclk_q[1] && st.sclk_q[2];
  assign cs_fall   = !st.cs_q[1] && st.cs_q[2];
  assign cs_rise   = st.cs_q[1] && !st.cs_q[2];
  assign op        = st.shift_in[`SUI_OP_HI:`SUI_OP_LO];

  // Word takes effect only when all sixteen bits arrived before select rose
  assign commit  = (st.phase != sui_pkg::SUI_IDLE) && cs_rise && (st.bit_cnt == `SUI_WORD_BITS);
  assign rx_take = rx_valid_i && st.rx_rdy;
  assign tx_pop  = st.tx_vld && tx_ready_i;
  assign fifo_wr = rx_take && !st.fifo_dis_n;

  sui_rx_fifo u_rx_fifo (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (fifo_wr),
    .wr_data_i (rx_data_i),
    .rd_en_i   (st.fifo_pop),
    .rd_data_o (fifo_rd_data),
    .empty_o   (fifo_empty),
    .level_o   (fifo_level)
  );

  // Whole next-state computation
  always_comb
  begin
    logic [7:0] rx_byte;
    logic       rx_avail;
    logic [7:0] tx_byte;
    logic       tx_push;
    logic [1:0] tx_idx;
    logic [4:0] lvl_next;
    rx_byte  = '0;
    rx_avail = 1'b0;
    tx_byte  = '0;
    tx_push  = 1'b0;
    tx_idx   = '0;
    lvl_next = '0;
    next_st  = st;

    // Three-stage synchronisers for clock and select, two-stage for data and clear-to-send
    next_st.sclk_q = {st.sclk_q[1:0], sclk_i};
    next_st.cs_q   = {st.cs_q[1:0], cs_n_i};
    next_st.din_q  = {st.din_q[0], din_i};
    next_st.cts_q  = {st.cts_q[0], cts_n_i};
    next_st.fifo_pop = 1'b0;

    // Byte offered to the host, from FIFO or single buffer
    rx_byte  = st.fifo_dis_n ? st.rx_hold : fifo_rd_data;
    rx_avail = st.fifo_dis_n ? st.rx_hold_vld : !fifo_empty;
    if (st.word7)
    begin
      rx_byte[`SUI_POS_DATA_MSB] = 1'b0;
    end

    // Serial framing
    case (st.phase)
      sui_pkg::SUI_IDLE:
      begin
        if (cs_fall)
        begin
          next_st.phase    = sui_pkg::SUI_SHIFT;
          next_st.bit_cnt  = '0;
          next_st.out_word = {rx_avail, (st.tx_cnt != `SUI_TXBUF_DEPTH), st.fifo_dis_n, 1'b0,
                              st.word7, st.irda, !st.cts_q[1], st.addr_seen, rx_byte};
          next_st.dout      = rx_avail;
          next_st.dout_oe_n = 1'b0;
        end
      end
      sui_pkg::SUI_SHIFT, sui_pkg::SUI_HOLD:
      begin
        if (cs_rise)
        begin
          next_st.phase     = sui_pkg::SUI_IDLE;
          next_st.dout_oe_n = 1'b1;
        end
        else if (sclk_rise && st.bit_cnt < `SUI_WORD_BITS)
        begin
          next_st.shift_in = {st.shift_in[14:0], st.din_q[1]};
          next_st.bit_cnt  = st.bit_cnt + 5'h01;
          if (st.bit_cnt == 5'h0F)
          begin
            next_st.phase = sui_pkg::SUI_HOLD;
          end
          // Command known after two bits; low byte not yet sent
          if (st.bit_cnt == 5'h01 && {st.shift_in[0], st.din_q[1]} == `SUI_OP_RCFG)
          begin
            next_st.out_word[`SUI_POS_DATA_MSB:0] = {4'h0, st.baud};
          end
        end
        else if (sclk_fall && st.bit_cnt != 5'h00 && st.bit_cnt < `SUI_WORD_BITS)
        begin
          next_st.dout = st.out_word[~st.bit_cnt[3:0]];
        end
      end
      default:
      begin
        next_st.phase     = sui_pkg::SUI_IDLE;
        next_st.dout_oe_n = 1'b1;
      end
    endcase

    // Effects of a completed word
    if (commit)
    begin
      case (op)
        `SUI_OP_WCFG:
        begin
          next_st.baud       = st.shift_in[`SUI_POS_BAUD_MSB:0];
          next_st.fifo_dis_n = st.shift_in[`SUI_POS_FIFODIS];
          next_st.word7      = st.shift_in[`SUI_POS_WORD7];
          next_st.irda       = st.shift_in[`SUI_POS_IRDA];
        end
        `SUI_OP_WDAT:
        begin
          tx_byte = st.shift_in[7:0];
          if (st.word7)
          begin
            tx_byte[7] = 1'b0;
          end
          tx_push = 1'b1;
        end
        `SUI_OP_RDAT:
        begin
          if (st.fifo_dis_n)
          begin
            next_st.rx_hold_vld = 1'b0;
          end
          else
          begin
            next_st.fifo_pop = !fifo_empty;
          end
          next_st.addr_seen = 1'b0;
        end
        default:
        begin
          next_st.baud = st.baud;
        end
      endcase
    end

    // Two-entry transmit buffer; a write into a full buffer is dropped
    if (tx_pop)
    begin
      next_st.tx_d0  = st.tx_d1;
      next_st.tx_cnt = st.tx_cnt - 2'h1;
    end
    tx_idx = next_st.tx_cnt;
    if (tx_push && tx_idx != `SUI_TXBUF_DEPTH)
    begin
      if (tx_idx == 2'h0)
      begin
        next_st.tx_d0 = tx_byte;
      end
      else
      begin
        next_st.tx_d1 = tx_byte;
      end
      next_st.tx_cnt = tx_idx + 2'h1;
    end
    next_st.tx_vld = (next_st.tx_cnt != 2'h0);

    // Receive side; new arrival wins over a clear by a read
    if (rx_take && st.fifo_dis_n)
    begin
      next_st.rx_hold     = rx_data_i;
      next_st.rx_hold_vld = 1'b1;
    end
    if (rx_take && rx_ninth_i)
    begin
      next_st.addr_seen = 1'b1;
    end
    // Ready looks one cycle ahead so a back-to-back write cannot overflow
    lvl_next = {1'b0, fifo_level} + {4'h0, fifo_wr} - {4'h0, next_st.fifo_pop};
    if (next_st.fifo_dis_n)
    begin
      next_st.rx_rdy = !next_st.rx_hold_vld;
    end
    else
    begin
      next_st.rx_rdy = (lvl_next < `SUI_FIFO_DEPTH) && !(st.fifo_dis_n && !fifo_empty);
    end
  end

  // Clear-to-send sampling keeps running through reset
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      st            <= '0;
      st.phase      <= sui_pkg::SUI_IDLE;
      st.cs_q       <= `SUI_CS_SYNC_RST;
      st.dout_oe_n  <= 1'b1;
      st.baud       <= `SUI_BAUD_RST;
      st.fifo_dis_n <= `SUI_FIFODIS_RST;
      st.word7      <= `SUI_WORD7_RST;
      st.irda       <= `SUI_IRDA_RST;
      st.rx_hold    <= `SUI_RXBYTE_RST;
      st.cts_q      <= next_st.cts_q;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign dout_o                = st.dout;
  assign dout_oe_n_o           = st.dout_oe_n;
  assign baud_divisor_select_o = st.baud;
  assign fifo_disable_n_o      = st.fifo_dis_n;
  assign word_length_7_o       = st.word7;
  assign infrared_mode_o       = st.irda;
  assign tx_valid_o            = st.tx_vld;
  assign transmit_byte_o       = st.tx_d0;
  assign rx_ready_o            = st.rx_rdy;
  assign net_address_seen_o    = st.addr_seen;

  default clocking sui_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_hiz_after_cs: assert property ((st.phase != sui_pkg::SUI_IDLE) && cs_rise |=> dout_oe_n_o)
    else $error("serial output still driven after select rose");

  a_first_bit: assert property ((st.phase == sui_pkg::SUI_IDLE) && cs_fall
    |=> !dout_oe_n_o && dout_o == st.out_word[15])
    else $error("bit 15 not presented at select fall");

  a_next_bits: assert property ((st.phase != sui_pkg::SUI_IDLE) && !cs_rise && !sclk_rise && sclk_fall
    && st.bit_cnt != 5'h00 && st.bit_cnt < 5'h10 |=> dout_o == st.out_word[~$past(st.bit_cnt[3:0])])
    else $error("output bit not advanced on clock fall");

  a_din_capture: assert property ((st.phase == sui_pkg::SUI_SHIFT) && sclk_rise && !cs_rise
    |=> st.shift_in[0] == $past(st.din_q[1]) && st.bit_cnt == $past(st.bit_cnt) + 5'h01)
    else $error("input bit not captured on clock rise");

  a_abort_keeps: assert property ((st.phase != sui_pkg::SUI_IDLE) && cs_rise && st.bit_cnt != 5'h10
    |=> $stable(baud_divisor_select_o) && $stable(fifo_disable_n_o) && $stable(infrared_mode_o)
        && $stable(word_length_7_o))
    else $error("short word changed configuration");

  a_count_restart: assert property ((st.phase == sui_pkg::SUI_IDLE) && cs_fall |=> st.bit_cnt == 5'h00)
    else $error("bit count not restarted at select fall");

  a_baud_load: assert property (commit && op == 2'h3
    |=> baud_divisor_select_o == $past(st.shift_in[3:0]) && infrared_mode_o == $past(st.shift_in[10]))
    else $error("config write not loaded at select rise");

  a_tx_len7: assert property (commit && op == 2'h2 && st.word7 && st.tx_cnt == 2'h0
    |=> tx_valid_o && !transmit_byte_o[7])
    else $error("top data bit kept in 7-bit length");

  a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(transmit_byte_o))
    else $error("transmit byte lost under stall");

endmodule // sui_host_port
`default_nettype wire

// *** dv/sui_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module sui_host_model (
  input  wire logic sys_clk_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic dout_i,
  input  wire logic dout_oe_n_i
);
  logic last = 1'b0;
  logic line;

  // Released line shows the inverse of its last driven level
  assign line = dout_oe_n_i ? ~last : dout_i;

  // Remember what the device last drove
  always @(posedge sys_clk_i)
    if (!dout_oe_n_i)
      last <= dout_i;

  // Idle: clock low, select high
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o  = 1'b0;
  end

  // One word, msb first; nbits below 16 aborts it mid-word
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    repeat (10) @(posedge sys_clk_i);
    cs_n_o <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    for (int i = 15; i > 15 - nbits; i--)
    begin
      din_o <= tx[i];
      repeat (10) @(posedge sys_clk_i);
      sclk_o <= 1'b1;
      rx[i] = line;
      repeat (10) @(posedge sys_clk_i);
      sclk_o <= 1'b0;
    end
    repeat (10) @(posedge sys_clk_i);
    cs_n_o <= 1'b1;
    din_o  <= ~din_o; // Unselected data line keeps moving
  endtask
endmodule // sui_host_model

`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sui_defines.svh"

module tb;
  logic        clk, rst_b_i, sclk, cs_n, din, dout, dout_oe_n, cts_n_i;
  logic [3:0]  baud;
  logic        fdis, w7, ir, tx_valid, tx_ready, rx_valid, rx_ninth, rx_ready, addr_seen, drain;
  logic [7:0]  tx_byte, rx_data;
  logic [3:0]  c_baud;
  logic        c_fd, c_w7, c_ir;
  logic [15:0] rw;
  logic [31:0] r;
  logic [7:0]  txq[$], texp[$], rxe[$];
  integer      seed = 32'h6c10f4bf;
  int          bad_count = 0;
  int          checks = 0;

  sui_host_port u_sui_host_port (.sys_clk_i(clk), .rst_b_i(rst_b_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .din_i(din), .dout_o(dout), .dout_oe_n_o(dout_oe_n), .cts_n_i(cts_n_i), .baud_divisor_select_o(baud),
    .fifo_disable_n_o(fdis), .word_length_7_o(w7), .infrared_mode_o(ir), .tx_valid_o(tx_valid),
    .transmit_byte_o(tx_byte), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_ninth_i(rx_ninth), .rx_ready_o(rx_ready), .net_address_seen_o(addr_seen));

  sui_host_model u_sui_host_model (.sys_clk_i(clk), .sclk_o(sclk), .cs_n_o(cs_n), .din_o(din),
    .dout_i(dout), .dout_oe_n_i(dout_oe_n));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Core side takes transmit bytes, stalling at random
  always @(posedge clk)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      txq.push_back(tx_byte);
    tx_ready <= drain && ($random(seed) % 2 != 0);
  end

  function automatic logic [15:0] exp_word(input logic rxa, room, addr, input logic [7:0] low);
    return {rxa, room, c_fd, 1'b0, c_w7, c_ir, ~cts_n_i, addr, low};
  endfunction

  task automatic chk_word(input logic [15:0] got, exp, mask);
    checks++;
    if ((got & mask) !== (exp & mask))
    begin
      bad_count++;
      $display("ERROR %0t word got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [7:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t output got %h exp %h", $time, got, exp);
    end
  endtask

  // A word, then room for the select rise to take effect
  task automatic word(input logic [15:0] tx, input int n);
    u_sui_host_model.xfer(tx, n, rw);
    repeat (6) @(posedge clk);
    chk_out({7'h00, dout_oe_n}, 8'h01);
  endtask

  task automatic cfg_wr(input logic fd, l7, irm, input logic [3:0] b);
    word({`SUI_OP_WCFG, fd, 1'b0, l7, irm, 6'h00, b}, 16);
    {c_fd, c_w7, c_ir, c_baud} = {fd, l7, irm, b};
    chk_out({1'b0, fdis, w7, ir, baud}, {1'b0, fd, l7, irm, b});
  endtask

  task automatic push_rx(input logic [7:0] d, input logic n);
    int k;
    @(posedge clk);
    rx_data  <= d;
    rx_ninth <= n;
    rx_valid <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (rx_ready === 1'b1)
        break;
    end
    if (k == 20)
      chk_out(8'h00, 8'h01);
    rx_valid <= 1'b0;
    rx_data  <= ~d;
  endtask

  task automatic results;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Watchdog; about thirty words of 360 cycles each, so 50000 cycles leaves ample margin
  initial
  begin
    #400000;
    bad_count++;
    results();
  end

  // Main sequence
  initial
  begin
    // Core offers nothing until the receive scenario; tx_ready belongs to the core process
    {rst_b_i, cts_n_i, drain, rx_valid, rx_data, rx_ninth} = 13'h0800;
    {c_fd, c_w7, c_ir, c_baud} = 7'h00;
    repeat (12) @(posedge clk);
    rst_b_i <= 1'b1;
    repeat (5) @(posedge clk);
    chk_out({1'b0, fdis, w7, ir, baud}, 8'h00);
    word({`SUI_OP_RCFG, 14'h0000}, 16);
    chk_word(rw, exp_word(1'b0, 1'b1, 1'b0, 8'h00), 16'hFFFF);
    for (int i = 0; i < 6; i++)
    begin
      r = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      cts_n_i <= r[20];
      if (i == 3)
      begin
        word({`SUI_OP_WCFG, 14'h3FFF}, 9); // Aborted word first
        chk_out({1'b0, fdis, w7, ir, baud}, {1'b0, c_fd, c_w7, c_ir, c_baud});
      end
      cfg_wr(r[0], r[1], r[2], r[6:3]);
      word({`SUI_OP_RCFG, 14'h0000}, 16);
      chk_word(rw, exp_word(1'b0, 1'b1, 1'b0, {4'h0, c_baud}), 16'hFFFF);
    end
    // Transmit: third byte dropped while the core stalls
    cfg_wr(1'b0, 1'b1, 1'b0, 4'h5);
    for (int i = 0; i < 3; i++)
    begin
      r = $random(seed) | 32'h80;
      word({`SUI_OP_WDAT, 6'h00, r[7:0]}, 16);
      chk_word(rw, exp_word(1'b0, i < 2, 1'b0, 8'h00), 16'hFFFF);
      if (i < 2)
        texp.push_back({1'b0, r[6:0]});
    end
    chk_out({7'h00, tx_valid}, 8'h01);
    chk_out(tx_byte, texp[0]);
    drain <= 1'b1;
    repeat (80) @(posedge clk);
    chk_out(8'(txq.size()), 8'h02);
    for (int k = 0; k < txq.size(); k++)
      chk_out(txq[k], texp[k]);
    // Receive: fill the eight-deep queue, then read it out
    cfg_wr(1'b0, 1'b0, 1'b1, 4'h2);
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      push_rx(r[7:0], i == 3);
      rxe.push_back(r[7:0]);
    end
    repeat (3) @(posedge clk);
    chk_out({6'h00, rx_ready, addr_seen}, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      word({`SUI_OP_RDAT, 14'h0000}, 16);
      chk_word(rw, exp_word(1'b1, 1'b1, i == 0, rxe[i]), 16'hFFFF);
    end
    chk_out({7'h00, addr_seen}, 8'h00);
    // Single buffer, 7-bit length
    cfg_wr(1'b1, 1'b1, 1'b0, 4'h2);
    push_rx(8'hFF, 1'b0);
    repeat (3) @(posedge clk);
    chk_out({7'h00, rx_ready}, 8'h00);
    word({`SUI_OP_RDAT, 14'h0000}, 16);
    chk_word(rw, exp_word(1'b1, 1'b1, 1'b0, 8'h7F), 16'hFFFF);
    results();
  end
endmodule // tb

`default_nettype wire
